// ---- core/asfw_defs.vh ----
`ifndef ASFW_DEFS_VH
`define ASFW_DEFS_VH

// Register bus geometry
`define ASFW_AW 4
`define ASFW_DW 16

// Word addresses on the register port
`define ASFW_ADDR_OPST 4'h4
`define ASFW_ADDR_CTST 4'h5
`define ASFW_ADDR_IRQST 4'h8
`define ASFW_ADDR_IRQCLR 4'h9
`define ASFW_ADDR_IRQEN 4'hA
`define ASFW_ADDR_FLGCLR 4'hB

// Operation status word bit positions
`define ASFW_OP_IFWAIT 7
`define ASFW_OP_IFPOS 8
`define ASFW_OP_MEM 11
`define ASFW_OP_STRQ 13
`define ASFW_OP_SVEL 14
`define ASFW_OP_SPOS 15

// Control status word bit positions
`define ASFW_CT_ORG 0
`define ASFW_CT_STOP 1
`define ASFW_CT_LATCH 2
`define ASFW_CT_OLATCH 3
`define ASFW_CT_CMD_OVF 4
`define ASFW_CT_CMD_UNF 5
`define ASFW_CT_FB_OVF 6
`define ASFW_CT_FB_UNF 7
`define ASFW_CT_SENS 8
`define ASFW_CT_SERVO 9
`define ASFW_CT_EXEC 10
`define ASFW_CT_WARN 11

// Interrupt status bit for the interrupt feeding input event
`define ASFW_IRQ_IFPOS 0

// Masks and reset values
`define ASFW_CT_STICKY 16'h0FFC
`define ASFW_IRQ_MASK 16'h0FFD
`define ASFW_ZERO16 16'h0000

// Interrupt feeding sequencer states
`define ASFW_ST_IDLE 2'h0
`define ASFW_ST_WAIT 2'h1
`define ASFW_ST_POSN 2'h2

// Synchronous feeding mode codes
`define ASFW_SM_NONE 2'h0
`define ASFW_SM_TRQ 2'h1
`define ASFW_SM_VEL 2'h2
`define ASFW_SM_POS 2'h3

`endif

// ---- core/asfw_sync.v ----
`timescale 1ns/10ps
`default_nettype none

module asfw_sync #(
    parameter WIDTH = 1
) (
    input wire i_clk,
    input wire i_rstn,
    input wire [WIDTH-1:0] i_d,
    output wire [WIDTH-1:0] o_q
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // Two stages; only the second is read outside
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;

endmodule

`default_nettype wire

// ---- core/asfw_top.v ----
// Behaviour
// [R01] Op bit 8 set after interrupt input asserts during interrupt feeding.
// [R02] Op bit 7 high in interrupt feeding until the interrupt input asserts.
// [R03] Op bit 11 high exactly while memory operation runs.
// [R04] Op bit 13 high while in synchronous torque mode.
// [R05] Op bit 14 high while in synchronous velocity mode.
// [R06] Op bit 15 high while in synchronous position mode.
// [R07] Control bit 0 reads 1 while origin defined, else 0.
// [R08] Control bit 1 high when stopped in position, gated by origin defined.
// [R09] Control bit 2 set when present position latched.
// [R10] Control bit 3 set when origin position latched.
// [R11] Linear mode: control bit 4 command overflow, bit 5 underflow.
// [R12] Linear mode: control bit 6 feedback overflow, bit 7 underflow.
// [R13] Control bit 8 set on external sensor fault.
// [R14] Control bit 9 set on servo drive alarm.
// [R15] Control bit 10 set on axis function operation error.
// [R16] Control bit 11 set on warning during memory operation.
// [R17] Op bits 9, 10 and 12 always read zero.
`timescale 1ns/10ps
`default_nettype none
`include "asfw_defs.vh"

module asfw_top #(
    parameter AW = `ASFW_AW,
    parameter DW = `ASFW_DW
) (
    input wire I_CLK,
    input wire I_RSTN,
    input wire [AW-1:0] I_ADDR,
    input wire [DW-1:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output reg [DW-1:0] O_RDATA,
    output wire O_IRQ,
    input wire I_INTR_PIN,
    input wire I_DRV_ALARM_PIN,
    input wire I_IFEED_START,
    input wire I_IFEED_END,
    input wire I_MEM_OP_ACTIVE,
    input wire [1:0] I_SYNC_MODE,
    input wire I_ORIGIN_DEFINED,
    input wire I_IN_POSITION,
    input wire I_LINEAR_MODE,
    input wire I_POS_LATCH,
    input wire I_ORG_LATCH,
    input wire I_CMD_OVF,
    input wire I_CMD_UNF,
    input wire I_FB_OVF,
    input wire I_FB_UNF,
    input wire I_SENSOR_FAULT,
    input wire I_EXEC_ERROR,
    input wire I_MEM_WARN,
    output reg [DW-1:0] O_OP_STATUS,
    output reg [DW-1:0] O_CTRL_STATUS
);

    localparam [1:0] ST_IDLE = `ASFW_ST_IDLE;
    localparam [1:0] ST_WAIT = `ASFW_ST_WAIT;
    localparam [1:0] ST_POSN = `ASFW_ST_POSN;

    // Pin synchronisation
    wire intr_s;
    wire alarm_s;
    reg intr_prev_q;
    reg alarm_prev_q;
    wire intr_rise;
    wire alarm_rise;

    asfw_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .i_clk(I_CLK),
        .i_rstn(I_RSTN),
        .i_d({I_DRV_ALARM_PIN, I_INTR_PIN}),
        .o_q({alarm_s, intr_s})
    );

    always @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            intr_prev_q <= 1'b0;
            alarm_prev_q <= 1'b0;
        end else begin
            intr_prev_q <= intr_s;
            alarm_prev_q <= alarm_s;
        end
    end

    assign intr_rise = intr_s & ~intr_prev_q;
    assign alarm_rise = alarm_s & ~alarm_prev_q;

    // Register port decode
    wire wr_irqclr;
    wire wr_irqen;
    wire wr_flgclr;

    assign wr_irqclr = I_WR & (I_ADDR == `ASFW_ADDR_IRQCLR);
    assign wr_irqen = I_WR & (I_ADDR == `ASFW_ADDR_IRQEN);
    assign wr_flgclr = I_WR & (I_ADDR == `ASFW_ADDR_FLGCLR);

    // Interrupt feeding sequencer
    reg [1:0] state_q;
    reg [1:0] state_d;
    wire intr_accept;

    assign intr_accept = (state_q == ST_WAIT) & intr_rise;

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (I_IFEED_START) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (I_IFEED_END) begin
                    state_d = ST_IDLE;
                end else if (intr_rise) begin
                    state_d = ST_POSN; // [R01]
                end
            end
            ST_POSN: begin
                if (I_IFEED_END) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Operation status word
    reg [DW-1:0] op_d;

    always @* begin
        op_d = `ASFW_ZERO16; // [R17]
        op_d[`ASFW_OP_IFWAIT] = (state_d == ST_WAIT); // [R02]
        op_d[`ASFW_OP_IFPOS] = (state_d == ST_POSN); // [R01]
        op_d[`ASFW_OP_MEM] = I_MEM_OP_ACTIVE; // [R03]
        op_d[`ASFW_OP_STRQ] = (I_SYNC_MODE == `ASFW_SM_TRQ); // [R04]
        op_d[`ASFW_OP_SVEL] = (I_SYNC_MODE == `ASFW_SM_VEL); // [R05]
        op_d[`ASFW_OP_SPOS] = (I_SYNC_MODE == `ASFW_SM_POS); // [R06]
    end

    always @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_OP_STATUS <= `ASFW_ZERO16;
        end else begin
            O_OP_STATUS <= op_d;
        end
    end

    // Control status events
    reg [DW-1:0] ct_set;
    wire [DW-1:0] ct_clr;
    reg [DW-1:0] ct_sticky_q;
    wire [DW-1:0] ct_live;

    always @* begin
        ct_set = `ASFW_ZERO16;
        ct_set[`ASFW_CT_LATCH] = I_POS_LATCH; // [R09]
        ct_set[`ASFW_CT_OLATCH] = I_ORG_LATCH; // [R10]
        ct_set[`ASFW_CT_CMD_OVF] = I_LINEAR_MODE & I_CMD_OVF; // [R11]
        ct_set[`ASFW_CT_CMD_UNF] = I_LINEAR_MODE & I_CMD_UNF; // [R11]
        ct_set[`ASFW_CT_FB_OVF] = I_LINEAR_MODE & I_FB_OVF; // [R12]
        ct_set[`ASFW_CT_FB_UNF] = I_LINEAR_MODE & I_FB_UNF; // [R12]
        ct_set[`ASFW_CT_SENS] = I_SENSOR_FAULT; // [R13]
        ct_set[`ASFW_CT_SERVO] = alarm_rise; // [R14]
        ct_set[`ASFW_CT_EXEC] = I_EXEC_ERROR; // [R15]
        ct_set[`ASFW_CT_WARN] = I_MEM_OP_ACTIVE & I_MEM_WARN; // [R16]
    end

    assign ct_clr = wr_flgclr ? (I_WDATA & `ASFW_CT_STICKY) : `ASFW_ZERO16;

    // Set wins over a clear in the same cycle
    always @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ct_sticky_q <= `ASFW_ZERO16;
        end else begin
            ct_sticky_q <= ((ct_sticky_q & ~ct_clr) | ct_set) &
                           `ASFW_CT_STICKY;
        end
    end

    assign ct_live = {{(DW-2){1'b0}},
                      I_ORIGIN_DEFINED & I_IN_POSITION, // [R08]
                      I_ORIGIN_DEFINED}; // [R07]

    always @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_CTRL_STATUS <= `ASFW_ZERO16;
        end else begin
            O_CTRL_STATUS <= ct_live | ct_sticky_q | ct_set;
        end
    end

    // Interrupt status, enable and clear
    reg [DW-1:0] irq_q;
    reg [DW-1:0] irq_en_q;
    reg [DW-1:0] irq_set;
    wire [DW-1:0] irq_clr;

    always @* begin
        irq_set = ct_set;
        irq_set[`ASFW_IRQ_IFPOS] = intr_accept;
    end

    assign irq_clr = wr_irqclr ? I_WDATA : `ASFW_ZERO16;

    always @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            irq_q <= `ASFW_ZERO16;
        end else begin
            irq_q <= ((irq_q & ~irq_clr) | irq_set) & `ASFW_IRQ_MASK;
        end
    end

    always @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            irq_en_q <= `ASFW_ZERO16;
        end else if (wr_irqen) begin
            irq_en_q <= I_WDATA & `ASFW_IRQ_MASK;
        end
    end

    assign O_IRQ = |(irq_q & irq_en_q);

    // Read data, valid only in the cycle after the read strobe
    reg [DW-1:0] rdata_d;

    always @* begin
        rdata_d = `ASFW_ZERO16;
        if (I_RD) begin
            case (I_ADDR)
                `ASFW_ADDR_OPST: begin
                    rdata_d = O_OP_STATUS;
                end
                `ASFW_ADDR_CTST: begin
                    rdata_d = O_CTRL_STATUS;
                end
                `ASFW_ADDR_IRQST: begin
                    rdata_d = irq_q;
                end
                `ASFW_ADDR_IRQEN: begin
                    rdata_d = irq_en_q;
                end
                default: begin
                    rdata_d = `ASFW_ZERO16;
                end
            endcase
        end
    end

    always @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_RDATA <= `ASFW_ZERO16;
        end else begin
            O_RDATA <= rdata_d;
        end
    end

endmodule

`default_nettype wire

// ---- tb/asfw_top_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module asfw_chk (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic [3:0] I_ADDR,
    input wire logic I_RD,
    input wire logic [15:0] O_RDATA,
    input wire logic I_IFEED_START,
    input wire logic I_IFEED_END,
    input wire logic I_MEM_OP_ACTIVE,
    input wire logic [1:0] I_SYNC_MODE,
    input wire logic I_ORIGIN_DEFINED,
    input wire logic I_IN_POSITION,
    input wire logic I_LINEAR_MODE,
    input wire logic I_POS_LATCH,
    input wire logic I_CMD_OVF,
    input wire logic [15:0] O_OP_STATUS,
    input wire logic [15:0] O_CTRL_STATUS
);
    wire [15:0] op = O_OP_STATUS;
    wire [15:0] ct = O_CTRL_STATUS;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    mem_flag_a: assert property ($past(I_RSTN) |->
        op[11] == $past(I_MEM_OP_ACTIVE)) else $error("mem flag");
    sync_pos_a: assert property ($past(I_RSTN) &&
        $past(I_SYNC_MODE) == 2'h3 |-> op[15:13] == 3'h4)
        else $error("sync position flag");
    spare_zero_a: assert property (op[12] == 1'b0 &&
        op[10:9] == 2'h0 && ct[15:12] == 4'h0) else $error("spare bits");
    origin_stop_a: assert property ($past(I_RSTN) |->
        ct[0] == $past(I_ORIGIN_DEFINED) && ct[1] ==
        $past(I_ORIGIN_DEFINED && I_IN_POSITION)) else $error("origin");
    feed_wait_a: assert property (I_IFEED_START && !I_IFEED_END &&
        op[8:7] == 2'h0 |=> op[8:7] == 2'h1) else $error("feed wait");
    feed_end_a: assert property (I_IFEED_END |=>
        op[8:7] == 2'h0) else $error("feed end");
    feed_posn_a: assert property ($rose(op[8]) |->
        $past(op[7])) else $error("feed position");
    latch_done_a: assert property (I_POS_LATCH |->
        ##[1:2] ct[2]) else $error("latch flag");
    cmd_ovf_a: assert property (I_CMD_OVF && I_LINEAR_MODE |->
        ##[1:2] ct[4]) else $error("overflow flag");
    rd_ctrl_a: assert property (I_RD && I_ADDR == 4'h5 |=>
        O_RDATA == $past(ct)) else $error("read data");
endmodule
bind asfw_top asfw_chk chk (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
    .I_ADDR(I_ADDR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_IFEED_START(I_IFEED_START), .I_IFEED_END(I_IFEED_END),
    .I_MEM_OP_ACTIVE(I_MEM_OP_ACTIVE), .I_SYNC_MODE(I_SYNC_MODE),
    .I_ORIGIN_DEFINED(I_ORIGIN_DEFINED), .I_IN_POSITION(I_IN_POSITION),
    .I_LINEAR_MODE(I_LINEAR_MODE), .I_POS_LATCH(I_POS_LATCH),
    .I_CMD_OVF(I_CMD_OVF), .O_OP_STATUS(O_OP_STATUS),
    .O_CTRL_STATUS(O_CTRL_STATUS));
`default_nettype wire

// ---- tb/asfw_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module asfw_host (
    input wire logic i_clk,
    input wire logic [15:0] i_rdata,
    output logic [3:0] o_addr,
    output logic [15:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        {o_addr, o_wdata, o_wr, o_rd} = '0;
    end
    // Released lines show inverted values, not the last ones
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask
endmodule
`default_nettype wire

// ---- tb/asfw_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module asfw_top_tb;
    logic clk, rstn, intr, st, en, mem, org, inp, lin, wr, rd, irq;
    logic [1:0] sm;
    logic [9:0] ev;
    logic [3:0] a;
    logic [15:0] wd, rdat, d, ex;
    int n_fail, n_tests;
    asfw_host host (.i_clk(clk), .i_rdata(rdat), .o_addr(a),
        .o_wdata(wd), .o_wr(wr), .o_rd(rd));
    asfw_top dut (.I_CLK(clk), .I_RSTN(rstn), .I_ADDR(a), .I_WDATA(wd),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdat), .O_IRQ(irq),
        .I_INTR_PIN(intr), .I_DRV_ALARM_PIN(ev[7]), .I_IFEED_START(st),
        .I_IFEED_END(en), .I_MEM_OP_ACTIVE(mem), .I_SYNC_MODE(sm),
        .I_ORIGIN_DEFINED(org), .I_IN_POSITION(inp), .I_LINEAR_MODE(lin),
        .I_POS_LATCH(ev[0]), .I_ORG_LATCH(ev[1]), .I_CMD_OVF(ev[2]),
        .I_CMD_UNF(ev[3]), .I_FB_OVF(ev[4]), .I_FB_UNF(ev[5]),
        .I_SENSOR_FAULT(ev[6]), .I_EXEC_ERROR(ev[8]), .I_MEM_WARN(ev[9]),
        .O_OP_STATUS(), .O_CTRL_STATUS());
    task automatic ck(input string n, input logic [15:0] e, s);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic rck(input logic [3:0] ad, input logic [15:0] e);
        host.rd(ad, d);
        ck($sformatf("word %h", ad), e, d);
    endtask
    task automatic conclude;
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        conclude;
    end
    initial begin
        {rstn, intr, st, en, mem, org, inp, lin, sm, ev} = '0;
        n_fail = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rck(4'h4, 16'h0000);
        rck(4'h5, 16'h0000);
        rck(4'h3, 16'h0000);
        host.wr(4'h4, 16'hFFFF);
        rck(4'h4, 16'h0000);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            @(posedge clk) sm <= m[1:0];
            mem <= m[0];
            ex = (16'h1000 << m) & 16'hE000 | {4'h0, m[0], 11'h000};
            rck(4'h4, ex);
        end
        @(posedge clk) sm <= 2'h0;
        inp <= 1'b1;
        rck(4'h5, 16'h0000);
        @(posedge clk) org <= 1'b1;
        rck(4'h5, 16'h0003);
        $display("test modes done");
        host.wr(4'hA, 16'h0001);
        @(posedge clk) st <= 1'b1;
        @(posedge clk) st <= 1'b0;
        rck(4'h4, 16'h0880);
        @(posedge clk) intr <= 1'b1;
        repeat (4) @(posedge clk);
        rck(4'h4, 16'h0900);
        ck("irq", 16'h0001, {15'h0000, irq});
        rck(4'h8, 16'h0001);
        host.wr(4'h9, 16'h0001);
        #1 ck("irq", 16'h0000, {15'h0000, irq});
        @(posedge clk) en <= 1'b1;
        @(posedge clk) en <= 1'b0;
        intr <= 1'b0;
        rck(4'h4, 16'h0800);
        @(posedge clk) st <= 1'b1;
        @(posedge clk) st <= 1'b0;
        en <= 1'b1;
        @(posedge clk) en <= 1'b0;
        intr <= 1'b1;
        repeat (4) @(posedge clk);
        rck(4'h4, 16'h0800);
        rck(4'h8, 16'h0000);
        @(posedge clk) intr <= 1'b0;
        $display("test feeding done");
        @(posedge clk) ev <= 10'h03C;
        @(posedge clk) ev <= 10'h000;
        repeat (3) @(posedge clk);
        rck(4'h5, 16'h0003);
        @(posedge clk) lin <= 1'b1;
        for (int k = 0; k < 10; k++) begin
            @(posedge clk) ev <= 10'h001 << k;
            @(posedge clk) ev <= 10'h000;
            repeat (3) @(posedge clk);
            ex = (16'h0008 << k) - 16'h0001;
            rck(4'h5, ex);
        end
        $display("test events done");
        ck("irq", 16'h0000, {15'h0000, irq});
        rck(4'h8, 16'h0FFC);
        host.wr(4'hA, 16'h0FFD);
        #1 ck("irq", 16'h0001, {15'h0000, irq});
        rck(4'hA, 16'h0FFD);
        host.wr(4'hB, 16'h0FFC);
        repeat (2) @(posedge clk);
        rck(4'h5, 16'h0003);
        host.wr(4'h9, 16'h0FFC);
        #1 ck("irq", 16'h0000, {15'h0000, irq});
        $display("test interrupts done");
        @(posedge clk) ev <= 10'h001;
        @(posedge clk) ev <= 10'h000;
        rck(4'h5, 16'h0007);
        @(posedge clk) rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rck(4'h5, 16'h0003);
        rck(4'hA, 16'h0000);
        rck(4'h8, 16'h0000);
        ck("irq", 16'h0000, {15'h0000, irq});
        $display("test mid-run reset done");
        conclude;
    end
endmodule
`default_nettype wire
